// ==== rtl/dasr_pkg.sv ====
/*
 * Shared constants and types for the dual serial converter readout link.
 * Assumes one 40 MHz system clock on both ends; no other dependencies.
 */
package dasr_pkg;

   // Clock rate of both ends
   localparam int unsigned CLK_PERIOD_PS = 25000;

   // Frame and result widths
   localparam int unsigned RESULT_BITS = 16;
   localparam int unsigned BIT_CNT_W   = 5;

   // Cycle timing figures in ns as printed
   localparam int unsigned CYCLE_PERIOD_MIN_NS    = 500;
   localparam int unsigned CYCLE_PERIOD_MAX_NS    = 1000000;
   localparam int unsigned CONVERSION_TIME_MIN_NS = 220;
   localparam int unsigned STROBE_HIGH_MIN_NS     = 25;
   // Shift clock least period, in ps (15.6 ns)
   localparam int unsigned SCK_PERIOD_MIN_PS      = 15600;

   // Least times rounded up to whole cycles, never below one
   function automatic int unsigned ceil_cycles(input int unsigned t_ps);
      int unsigned n;
      n = (t_ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (n < 1) ? 1 : n;
   endfunction : ceil_cycles

   localparam int unsigned CYCLE_MIN_CYC   = ceil_cycles(CYCLE_PERIOD_MIN_NS * 1000);
   localparam int unsigned CONV_MIN_CYC    = ceil_cycles(CONVERSION_TIME_MIN_NS * 1000);
   localparam int unsigned CNVH_MIN_CYC    = ceil_cycles(STROBE_HIGH_MIN_NS * 1000);
   // Half shift period: at least one cycle high and one low
   localparam int unsigned SCK_HALF_CYC    = ceil_cycles(SCK_PERIOD_MIN_PS / 2);
   // Longest period, counted as a longest time, rounded down
   localparam int unsigned CYCLE_MAX_CYC   = (CYCLE_PERIOD_MAX_NS * 1000) / CLK_PERIOD_PS;

   localparam int unsigned TMR_W = 16;

   // The far end sees a link edge only after its three-stage synchroniser
   // and the edge detector behind it, so each shift clock half must outlast that
   localparam int unsigned SYNC_LAT_CYC = 4;

   // I/O standard strap decode
   typedef enum logic [1:0] {
      DASR_IO_CMOS  = 2'h0,
      DASR_IO_LVDS  = 2'h1,
      DASR_IO_LPLVD = 2'h3
   } dasr_io_mode_t;

endpackage : dasr_pkg

// ==== rtl/dasr_if.sv ====
/*
 * Link between host and converter: strobe, shift clock, two data lines,
 * echo clock and the strap pins. Differential pins carry both halves.
 * Assumes a testbench resolves the three-state data from the enables.
 */
`timescale 1ns/10ps
interface dasr_if;
   logic convert_start_n;     // Active-low convert strobe from host
   logic sck_p;               // Shift clock, positive half
   logic sck_n;               // Shift clock, negative half
   logic ch1_serial_out_p;    // Channel 1 data, positive half
   logic ch1_serial_out_n;    // Channel 1 data, negative half
   logic ch2_serial_out_p;    // Channel 2 data, positive half
   logic ch2_serial_out_n;    // Channel 2 data, negative half
   logic sdo_oe;              // Data lines driven while high
   logic echo_clock_out_p;    // Echo clock, positive half
   logic echo_clock_out_n_o;  // Echo clock, negative half (device drive)
   logic echo_clock_out_n_oe; // Negative echo half driven
   logic echo_off_strap;      // Negative echo pin tied to io_supply
   logic [1:0] io_sel;        // Mode strap: 0 gnd, 1 supply, 3 float

   modport device (
      input  convert_start_n, sck_p, sck_n, echo_off_strap, io_sel,
      output ch1_serial_out_p, ch1_serial_out_n, ch2_serial_out_p, ch2_serial_out_n,
      output sdo_oe, echo_clock_out_p, echo_clock_out_n_o, echo_clock_out_n_oe
   );
   modport host (
      output convert_start_n, sck_p, sck_n,
      input  ch1_serial_out_p, ch1_serial_out_n, ch2_serial_out_p, ch2_serial_out_n,
      input  sdo_oe, echo_clock_out_p, echo_off_strap, io_sel
   );
endinterface : dasr_if

// ==== rtl/dasr_device.sv ====
/*
 * Converter end: samples two results on the strobe falling edge and
 * shifts them MSB first on shift clock falling edges, with echo clock.
 * Assumes the host keeps its own timing; link pins arrive asynchronous.
 */
//
// Contract
// (RULE_01) Strobe fall holds both samples, starts cycle
// (RULE_02) Cycle: strobe high, conversion, readout bounds
// (RULE_03) Host parks shift clock high before strobe rise
// (RULE_04) Each shift clock fall advances one bit
// (RULE_05) First bit valid soon after strobe falls
// (RULE_06) Data released soon after strobe rises
// (RULE_07) Host shift period bounded, captures on rise; host captures as it drives the fall
// (RULE_08) Echo clock follows shift clock, data aligned
// (RULE_09) Echo may be disabled; host uses own clock
// (RULE_10) Strap selects CMOS, LVDS or low-power LVDS
// (RULE_11) CMOS uses positive pins; LVDS differential
// (RULE_12) Strobe behaves same in all modes
// (RULE_13) Channel two shifts on same edges
// (RULE_14) Sixteen bits, current conversion, no latency
// (RULE_15) Results are two's complement
// (RULE_16) Host gives sixteen pulses while strobe low
`timescale 1ns/10ps
module dasr_device
   import dasr_pkg::*;
#(
   parameter int unsigned WIDTH = RESULT_BITS
) (
   input  wire logic               mclk_i,
   input  wire logic               sys_rst_i,
   dasr_if.device                  link,
   input  wire logic signed [WIDTH-1:0] ch1_sample_i,
   input  wire logic signed [WIDTH-1:0] ch2_sample_i,
   output logic                    busy_o,
   output dasr_pkg::dasr_io_mode_t io_mode_o
);
   import dasr_pkg::*;

   // Three-stage synchronisers; first stage feeds only the second
   logic [2:0] cnv_s_q;   // Strobe
   logic [2:0] sck_s_q;   // Shift clock (positive half)
   logic       cnv_q;     // Agreed strobe level
   logic       sck_q;     // Agreed shift clock level
   logic [WIDTH-1:0] sh1_q;   // Channel 1 shift register
   logic [WIDTH-1:0] sh2_q;   // Channel 2 shift register
   logic       oe_q;      // Data lines driven
   logic       echo_q;    // Echo clock level
   logic       busy_q;
   dasr_io_mode_t mode_q;

   // Synchronise strobe and shift clock; the strobe path ignores mode
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         cnv_s_q <= 3'h7;
         sck_s_q <= 3'h7;
         cnv_q   <= 1'b1;
         sck_q   <= 1'b1;
      end else begin
         cnv_s_q <= {cnv_s_q[1:0], link.convert_start_n}; // see RULE_12
         sck_s_q <= {sck_s_q[1:0], link.sck_p};
         // A change counts once the last two stages agree
         if (cnv_s_q[1] == cnv_s_q[2]) begin
            cnv_q <= cnv_s_q[2];
         end
         if (sck_s_q[1] == sck_s_q[2]) begin
            sck_q <= sck_s_q[2];
         end
      end
   end

   // Events seen at the agreed levels
   logic cnv_fall, cnv_rise, sck_fall;
   assign cnv_fall = cnv_q && (cnv_s_q[1] == cnv_s_q[2]) && !cnv_s_q[2];
   assign cnv_rise = !cnv_q && (cnv_s_q[1] == cnv_s_q[2]) && cnv_s_q[2];
   assign sck_fall = sck_q && (sck_s_q[1] == sck_s_q[2]) && !sck_s_q[2];

   // Mode strap followed every cycle after reset release, one cycle behind
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         mode_q <= DASR_IO_CMOS;
      end else begin
         mode_q <= dasr_io_mode_t'(link.io_sel); // see RULE_10
      end
   end

   // Hold, shift and release of the result registers
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         sh1_q  <= '0;
         sh2_q  <= '0;
         oe_q   <= 1'b0;
         busy_q <= 1'b0;
      end else if (cnv_fall) begin
         // Hold both channels at once; result belongs to this strobe
         sh1_q  <= ch1_sample_i; // see RULE_01 see RULE_14 see RULE_15
         sh2_q  <= ch2_sample_i; // see RULE_13
         oe_q   <= 1'b1;         // see RULE_05
         busy_q <= 1'b1;
      end else if (cnv_rise) begin
         oe_q   <= 1'b0;         // see RULE_06
         busy_q <= 1'b0;
      end else if (sck_fall && oe_q) begin
         // Extra pulses beyond sixteen shift zeros: undefined to host
         sh1_q <= {sh1_q[WIDTH-2:0], 1'b0}; // see RULE_04
         sh2_q <= {sh2_q[WIDTH-2:0], 1'b0}; // see RULE_13
      end
   end

   // Echo copies the synchronised shift clock, one cycle behind
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         echo_q <= 1'b1;
      end else begin
         echo_q <= sck_q; // see RULE_08
      end
   end

   // Pins: CMOS holds negative data halves low and leaves negative echo undriven; LVDS drives both
   assign link.ch1_serial_out_p    = sh1_q[WIDTH-1];
   assign link.ch2_serial_out_p    = sh2_q[WIDTH-1];
   assign link.ch1_serial_out_n    = (mode_q == DASR_IO_CMOS) ? 1'b0 : !sh1_q[WIDTH-1]; // see RULE_11
   assign link.ch2_serial_out_n    = (mode_q == DASR_IO_CMOS) ? 1'b0 : !sh2_q[WIDTH-1];
   assign link.sdo_oe              = oe_q;
   // Echo disabled in CMOS mode when its negative pin is strapped
   assign link.echo_clock_out_p    = (mode_q == DASR_IO_CMOS && link.echo_off_strap) ? 1'b0
                                     : echo_q; // see RULE_09
   assign link.echo_clock_out_n_o  = !echo_q;
   assign link.echo_clock_out_n_oe = (mode_q != DASR_IO_CMOS);

   assign busy_o    = busy_q;
   assign io_mode_o = mode_q;

endmodule : dasr_device

// ==== rtl/dasr_host.sv ====
/*
 * Host end: issues strobe cycles, sixteen shift pulses per frame, and
 * captures both channels at the end of each high half, as it drives the shift clock low.
 * Assumes the device answers within SYNC_LAT_CYC system cycles of each edge.
 */
`timescale 1ns/10ps
module dasr_host
   import dasr_pkg::*;
#(
   parameter int unsigned WIDTH     = RESULT_BITS,
   parameter int unsigned CYCLE_CYC = CYCLE_MIN_CYC
) (
   input  wire logic               mclk_i,
   input  wire logic               sys_rst_i,
   dasr_if.host                    link,
   input  wire logic               start_i,
   output logic signed [WIDTH-1:0] ch1_data_o,
   output logic signed [WIDTH-1:0] ch2_data_o,
   output logic                    valid_o
);
   import dasr_pkg::*;

   // Shift clock half period: the least legal half plus the far end's sync lag;
   // a one-cycle half would never settle through a three-stage synchroniser
   localparam int unsigned HALF_CYC = SCK_HALF_CYC + SYNC_LAT_CYC;

   typedef enum logic [2:0] {
      DASR_H_IDLE = 3'h0,
      DASR_H_CNVH = 3'h1,
      DASR_H_CONV = 3'h3,
      DASR_H_SHFT = 3'h2,
      DASR_H_PARK = 3'h6
   } dasr_hstate_t;

   dasr_hstate_t st_q;
   logic [TMR_W-1:0]     tmr_q;  // Phase timer
   logic [TMR_W-1:0]     cyc_q;  // Whole cycle timer
   logic [BIT_CNT_W-1:0] bit_q;  // Pulses issued
   logic                 cnv_q, sck_q, valid_q;
   logic [WIDTH-1:0]     rx1_q, rx2_q, out1_q, out2_q;

   // Strobe and shift sequencer
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         st_q <= DASR_H_IDLE; tmr_q <= '0; cyc_q <= '0; bit_q <= '0;
         cnv_q <= 1'b1; sck_q <= 1'b1; valid_q <= 1'b0;
         rx1_q <= '0; rx2_q <= '0; out1_q <= '0; out2_q <= '0;
      end else begin
         valid_q <= 1'b0;
         if (cyc_q != '0) cyc_q <= cyc_q - 1'b1;
         case (st_q)
            DASR_H_IDLE: begin
               if (start_i && cyc_q == '0) begin
                  st_q <= DASR_H_CNVH;
                  tmr_q <= TMR_W'(CNVH_MIN_CYC);
               end
            end
            DASR_H_CNVH: begin // Strobe high time before the fall
               if (tmr_q <= 1) begin
                  cnv_q <= 1'b0; // see RULE_02
                  cyc_q <= TMR_W'(CYCLE_CYC);
                  tmr_q <= TMR_W'(CONV_MIN_CYC);
                  st_q  <= DASR_H_CONV;
               end else tmr_q <= tmr_q - 1'b1;
            end
            DASR_H_CONV: begin // Wait out the conversion time
               if (tmr_q <= 1) begin
                  st_q <= DASR_H_SHFT; bit_q <= '0;
                  tmr_q <= TMR_W'(HALF_CYC);
               end else tmr_q <= tmr_q - 1'b1;
            end
            DASR_H_SHFT: begin // Sixteen pulses, capture as clock falls
               if (tmr_q <= 1) begin
                  tmr_q <= TMR_W'(HALF_CYC); // see RULE_07
                  if (sck_q) begin
                     if (bit_q == BIT_CNT_W'(WIDTH)) begin
                        // No capture after the last pulse: that bit is undefined
                        st_q <= DASR_H_PARK; // see RULE_16
                     end else begin
                        // Capture the current bit before it advances
                        rx1_q <= {rx1_q[WIDTH-2:0], link.ch1_serial_out_p};
                        rx2_q <= {rx2_q[WIDTH-2:0], link.ch2_serial_out_p};
                        sck_q <= 1'b0;
                     end
                  end else begin
                     sck_q <= 1'b1;
                     bit_q <= bit_q + 1'b1;
                  end
               end else tmr_q <= tmr_q - 1'b1;
            end
            DASR_H_PARK: begin // Clock parked high before strobe rises
               if (cyc_q <= TMR_W'(CNVH_MIN_CYC)) begin
                  cnv_q <= 1'b1; // see RULE_03
                  out1_q <= rx1_q; out2_q <= rx2_q; valid_q <= 1'b1;
                  st_q <= DASR_H_IDLE;
               end
            end
            default: st_q <= DASR_H_IDLE;
         endcase
      end
   end

   assign link.convert_start_n = cnv_q;
   assign link.sck_p           = sck_q;
   assign link.sck_n           = !sck_q;
   assign ch1_data_o = out1_q;
   assign ch2_data_o = out2_q;
   assign valid_o    = valid_q;

endmodule : dasr_host

// ==== tb/dasr_link_chk.sv ====
/*
 * Checker of the host-to-converter link, fed from the interface signals.
 * Assumes one system clock with synchronous active-high reset.
 */
`timescale 1ns/10ps
module dasr_link_chk
   import dasr_pkg::*;
(
   input wire logic       mclk_i,
   input wire logic       sys_rst_i,
   input wire logic       convert_start_n,
   input wire logic       sck_p,
   input wire logic       ch1_serial_out_p,
   input wire logic       ch1_serial_out_n,
   input wire logic       ch2_serial_out_p,
   input wire logic       ch2_serial_out_n,
   input wire logic       sdo_oe,
   input wire logic       echo_clock_out_p,
   input wire logic       echo_off_strap,
   input wire logic [1:0] io_sel
);
   logic [15:0] gap_q;  // Cycles since the last strobe fall, saturating
   logic [4:0]  bits_q; // Shift pulses seen in this frame
   logic        sck_q;  // Shift clock one cycle ago
   logic        cs_q;   // Strobe one cycle ago

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);

   // Period counter; saturates so a long idle never wraps into a false short gap
   always_ff @(posedge mclk_i) begin
      cs_q <= convert_start_n;
      if (sys_rst_i) gap_q <= 16'hffff;
      else if (!convert_start_n && cs_q) gap_q <= 16'h0001;
      else if (gap_q != 16'hffff) gap_q <= gap_q + 16'h0001;
   end

   // Rising shift edges counted while the strobe is low
   always_ff @(posedge mclk_i) begin
      sck_q <= sck_p;
      if (sys_rst_i || convert_start_n) bits_q <= 5'h00;
      else if (sck_p && !sck_q) bits_q <= bits_q + 5'h01;
   end

   // Shift clock quiet for the whole conversion time
   sequence s_conv;
      sck_p[*8] ##1 sck_p;
   endsequence

   a_oe_after_fall: assert property ($fell(convert_start_n) |-> ##[0:4] sdo_oe)
      else $error("data not driven after strobe fall");
   a_oe_release: assert property ($rose(convert_start_n) |-> ##[0:4] !sdo_oe)
      else $error("data not released after strobe rise");
   a_period_min: assert property ($fell(convert_start_n) |-> gap_q >= CYCLE_MIN_CYC)
      else $error("strobe period too short");
   a_conv_quiet: assert property ($fell(convert_start_n) |-> s_conv)
      else $error("shift clock active during conversion");
   a_sck_parked: assert property ($rose(convert_start_n) |-> sck_p)
      else $error("shift clock not parked high at strobe rise");
   a_sck_in_frame: assert property (!sck_p |-> !convert_start_n)
      else $error("shift clock low outside frame");
   a_frame_bits: assert property ($rose(convert_start_n) |->
      (bits_q == 5'h10) || (bits_q == 5'h0f && sck_p && !sck_q))
      else $error("frame pulse count not sixteen");
   a_echo_follows: assert property ($fell(sck_p) && (io_sel != 2'h0 || !echo_off_strap)
      |-> ##[1:6] !echo_clock_out_p)
      else $error("echo clock did not follow shift clock");
   a_lvds_pairs: assert property (sdo_oe && io_sel != 2'h0 && $stable(io_sel) |->
      ch1_serial_out_n == !ch1_serial_out_p && ch2_serial_out_n == !ch2_serial_out_p)
      else $error("data pair not differential");
endmodule : dasr_link_chk

// ==== tb/test_dual_adc_serial_readout.sv ====
/*
 * Top bench: host and converter ends joined over the link, framed with known samples.
 * Assumes the package, interface and both design ends are compiled first.
 */
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin err_count++; \
   $display("mismatch %s exp %h got %h", nm, exp, got); end end
module test_dual_adc_serial_readout;
   import dasr_pkg::*;
   logic               mclk_i    = 1'b0; // System clock
   logic               sys_rst_i = 1'b1; // Reset held at start
   logic               start_i   = 1'b0; // Cycle request
   logic signed [15:0] s1        = '0;   // Channel 1 sample
   logic signed [15:0] s2        = '0;   // Channel 2 sample
   logic signed [15:0] d1;               // Host result, channel 1
   logic signed [15:0] d2;               // Host result, channel 2
   logic               valid_o;          // Host result strobe
   logic               busy_o;           // Converter busy
   dasr_io_mode_t      io_mode_o;        // Decoded strap
   logic [16:0]        w1;               // Bits caught on the wire, MSB first
   logic               echo_q;           // Echo clock one cycle ago
   logic               oe_d;             // Data enable one cycle ago
   logic [1:0]         md [3] = '{2'h0, 2'h1, 2'h3};
   logic [15:0]        va [4] = '{16'h8000, 16'h7fff, 16'h0001, 16'ha5c3};
   logic [15:0]        vb [4] = '{16'h7fff, 16'h8000, 16'hffff, 16'h3c5a};
   int                 err_count  = 0;
   int                 num_checks = 0;
   int                 cyc        = 0;

   dasr_if link ();
   dasr_device u_dasr_device (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .link(link.device),
      .ch1_sample_i(s1), .ch2_sample_i(s2), .busy_o(busy_o), .io_mode_o(io_mode_o));
   dasr_host u_dasr_host (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .link(link.host),
      .start_i(start_i), .ch1_data_o(d1), .ch2_data_o(d2), .valid_o(valid_o));
   dasr_link_chk u_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
      .convert_start_n(link.convert_start_n), .sck_p(link.sck_p),
      .ch1_serial_out_p(link.ch1_serial_out_p), .ch1_serial_out_n(link.ch1_serial_out_n),
      .ch2_serial_out_p(link.ch2_serial_out_p), .ch2_serial_out_n(link.ch2_serial_out_n),
      .sdo_oe(link.sdo_oe), .echo_clock_out_p(link.echo_clock_out_p),
      .echo_off_strap(link.echo_off_strap), .io_sel(link.io_sel));

   // 40 MHz clock
   always #12.5 mclk_i = ~mclk_i;

   // Hang guard; a frame takes about 180 cycles, so this is far above need
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         results();
      end
   end

   // Receiver view: MSB caught when data is first driven, then one bit per echo rise;
   // the bit after the sixteenth pulse lands in the bottom and is ignored
   always @(posedge mclk_i) begin
      echo_q <= link.echo_clock_out_p;
      oe_d   <= link.sdo_oe;
      if (link.sdo_oe && !oe_d) w1 <= {16'h0000, link.ch1_serial_out_p};
      else if (link.echo_clock_out_p && !echo_q) w1 <= {w1[15:0], link.ch1_serial_out_p};
   end

   // One frame: request, drop request once strobe falls, await and compare result
   task automatic frame(input logic [15:0] a, input logic [15:0] b, input logic echo);
      int n = 0;
      s1 <= a;
      s2 <= b;
      start_i <= 1'b1;
      while (link.convert_start_n !== 1'b0 && n < 100) begin
         @(posedge mclk_i);
         n++;
      end
      start_i <= 1'b0;
      repeat (6) @(negedge mclk_i);
      `CHK("busy", 1'b1, busy_o)
      while (valid_o !== 1'b1 && n < 1000) begin
         @(negedge mclk_i);
         n++;
      end
      `CHK("ch1", a, d1)
      `CHK("ch2", b, d2)
      if (echo) `CHK("wire", a, w1[16:1])
      @(posedge mclk_i);
   endtask : frame

   // Verdict and end of run
   task automatic results();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results

   initial begin
      int g;
      link.io_sel = 2'h0;
      link.echo_off_strap = 1'b0;
      repeat (8) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      @(posedge mclk_i);
      // Every strap mode with boundary codes, strobe handling unchanged
      for (int m = 0; m < 3; m++) begin
         link.io_sel <= md[m];
         repeat (2) @(posedge mclk_i);
         `CHK("mode", dasr_io_mode_t'(md[m]), io_mode_o)
         for (int v = 0; v < 4; v++) frame(va[v], vb[v], 1'b1);
      end
      // Echo switched off in CMOS: host still reads on its own clock
      link.io_sel <= 2'h0;
      link.echo_off_strap <= 1'b1;
      repeat (2) @(posedge mclk_i);
      frame(16'hc001, 16'h1234, 1'b0);
      // Back-to-back cycles keep the least spacing
      link.echo_off_strap <= 1'b0;
      start_i <= 1'b1;
      g = 0;
      while (valid_o !== 1'b1 && g < 1000) begin
         @(negedge mclk_i);
         g++;
      end
      g = 0;
      @(negedge mclk_i);
      while (valid_o !== 1'b1 && g < 1000) begin
         @(negedge mclk_i);
         g++;
      end
      `CHK("spacing", 1'b1, (g + 1 >= CYCLE_MIN_CYC))
      @(posedge mclk_i);
      start_i <= 1'b0;
      repeat (30) @(posedge mclk_i);
      results();
   end
endmodule : test_dual_adc_serial_readout
